// File: reset_gen_pkg.sv
// Constants for the chip reset generator: register map, field layout, timings.
// Assumes a 250 MHz APB clock.
package reset_gen_pkg;
	localparam int          CLK_MHZ          = 250;
	localparam int          REGULATOR_INPUT_SUPPLY_TIME_MS     = 8;
	localparam int          ANA_TIME_MS      = 4;
	localparam int          REGULATOR_INPUT_SUPPLY_CYCLES      = REGULATOR_INPUT_SUPPLY_TIME_MS * 1000 * CLK_MHZ;
	localparam int          ANA_CYCLES       = ANA_TIME_MS * 1000 * CLK_MHZ;
	localparam int          RST_MIN_CYCLES   = 3;
	localparam logic [11:0] CORE_RISE_MV     = 12'h3b6;
	localparam logic [11:0] CORE_FALL_MV     = 12'h352;
	localparam logic [11:0] ADDR_STATUS      = 12'h000;
	localparam logic [11:0] ADDR_MASK        = 12'h004;
	localparam logic [11:0] ADDR_PERIPH_RST  = 12'h008;
	localparam logic [11:0] ADDR_CONTROL     = 12'h00c;
	localparam logic [11:0] ADDR_LEVELS      = 12'h010;
	localparam int          EVT_RELEASE      = 0;
	localparam int          EVT_POWER_FAIL   = 1;
	localparam int          EVT_RTC_LOST     = 2;
	localparam int          NUM_EVT          = 3;
	localparam int          NUM_PERIPH       = 16;
	localparam int          SYNC_W           = 4;
	localparam logic [2:0]  MASK_RESET       = 3'h0;
	localparam logic [15:0] PERIPH_RESET     = 16'h0000;
	localparam logic [1:0]  BA_RESET_LEVEL   = 2'h3;
	localparam logic [20:0] ADDR_RESET_LEVEL = 21'h000000;
	typedef enum logic [2:0]
	{
		ST_RESET   = 3'h1,
		ST_SEQ     = 3'h2,
		ST_RUN     = 3'h4
	} seq_state_e;
endpackage

// File: chip_reset_generator.sv
// Chip reset generator: combines reset pin and power-good, drives pin groups
// during reset, holds RTC power-lost flag, APB register file with interrupt.
// Assumes supply monitors arrive as asynchronous levels and a millivolt word.
// Behaviour
// - Hardware reset is pin AND power-good
// - Regulator disabled forces power-good high
// - Power-good waits for supplies and voltage
// - Threshold drops to lower level after good
// - Global reset spares the RTC domain
// - Reset release starts the boot sequence
// - Clock generator enabled after hardware reset
// - Deep idle clock picks reference by pin
// - RTC supply power-on resets RTC registers
// - RTC power-on reset sets power-lost flag
// - Software peripheral and CPU resets distinct
// - Output pin groups forced during reset
// - Synchronous pin groups step to reset level
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module chip_reset_generator
(
	input  wire logic        pclk,               // APB and system clock
	input  wire logic        presetn,            // APB reset, active low
	input  wire logic [11:0] paddr,              // APB byte address
	input  wire logic        psel,               // APB select
	input  wire logic        penable,            // APB access phase
	input  wire logic        pwrite,             // APB direction
	input  wire logic [31:0] pwdata,             // APB write data
	output logic      [31:0] prdata,             // APB read data
	output logic             pready,             // APB ready
	output logic             pslverr,            // APB error
	input  wire logic        reset_pin_n,        // External reset pin
	input  wire logic        core_regulator_enable_n, // High disables regulator
	input  wire logic        regulator_input_supply,  // Regulator input and bandgap up
	input  wire logic        analog_supply,      // Analog supply up
	input  wire logic [11:0] core_regulator_output, // Core voltage in mV
	input  wire logic        rtc_core_supply,    // RTC core supply up
	input  wire logic        deep_idle_mode,     // Deep idle request
	input  wire logic        ref_clock_select,   // 1 external ref, 0 RTC clock
	output logic             power_ok_flag,      // Power-good
	output logic             global_reset_n,     // Chip reset except RTC
	output logic             rtc_reset_n,        // RTC domain reset
	output logic             clock_gen_enable,   // Clock generator enable
	output logic             clock_gen_bypass,   // Clock generator bypass
	output logic             bypass_use_ext_ref, // Bypass source is external ref
	output logic             boot_start,         // One-cycle boot start pulse
	output logic [reset_gen_pkg::NUM_PERIPH-1:0] periph_reset_n, // Peripheral resets
	output logic             cpu_soft_reset,     // CPU soft reset pulse
	output logic             pin_override,       // Pin groups overridden
	output logic             group_high_out,     // High group level
	output logic             group_low_out,      // Low group level
	output logic             group_z_oe,         // Z group enable
	output logic             sync01_out,         // Sync 0 to 1 group
	output logic             sync10_out,         // Sync 1 to 0 group
	output logic [1:0]       mem_bank_addr_pins, // Bank address level
	output logic [20:0]      mem_addr_pins,      // Address level
	output logic             irq                 // Interrupt, active high
);
	import reset_gen_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [SYNC_W-1:0] s1_reg;
	logic [SYNC_W-1:0] s2_reg;
	logic [SYNC_W-1:0] async_in;
	logic              pin_s;
	logic              ldo_off_s;
	logic              regulator_input_supply_s;
	logic              ana_s;
	logic [11:0]       vcore_s1_reg;
	logic [11:0]       vcore_reg;
	logic              rtc_s1_reg;
	logic              rtc_s2_reg;

	assign async_in = {analog_supply, regulator_input_supply, core_regulator_enable_n, reset_pin_n};
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_reg     <= '0;
			s2_reg     <= '0;
			vcore_s1_reg <= 12'h000;
			vcore_reg  <= 12'h000;
			rtc_s1_reg <= 1'b0;
			rtc_s2_reg <= 1'b0;
		end
		else
		begin
			s1_reg     <= async_in;
			s2_reg     <= s1_reg;
			// Millivolt word is quasi-static; a sample taken mid-change may be off for one cycle
			vcore_s1_reg <= core_regulator_output;
			vcore_reg  <= vcore_s1_reg;
			rtc_s1_reg <= rtc_core_supply;
			rtc_s2_reg <= rtc_s1_reg;
		end
	end
	assign pin_s     = s2_reg[0];
	assign ldo_off_s = s2_reg[1];
	assign regulator_input_supply_s    = s2_reg[2];
	assign ana_s     = s2_reg[3];

	////////////////////////////////////////////////////////////////////////
	// Power-on detector
	logic [31:0] regulator_input_supply_cnt_reg;
	logic [31:0] regulator_input_supply_cnt_next;
	logic [31:0] ana_cnt_reg;
	logic [31:0] ana_cnt_next;
	logic        pgood_reg;
	logic        pgood_next;
	logic        regulator_input_supply_done;
	logic        ana_done;

	assign regulator_input_supply_done = (regulator_input_supply_cnt_reg >= 32'(REGULATOR_INPUT_SUPPLY_CYCLES));
	assign ana_done  = (ana_cnt_reg >= 32'(ANA_CYCLES));
	always_comb
	begin
		regulator_input_supply_cnt_next = regulator_input_supply_s ? (regulator_input_supply_done ? regulator_input_supply_cnt_reg : regulator_input_supply_cnt_reg + 32'h1) : 32'h0;
		ana_cnt_next  = ana_s ? (ana_done ? ana_cnt_reg : ana_cnt_reg + 32'h1) : 32'h0;
		if (ldo_off_s)
			pgood_next = 1'b1;
		else if (pgood_reg)
			pgood_next = regulator_input_supply_s && ana_s && (vcore_reg > CORE_FALL_MV);
		else
			pgood_next = regulator_input_supply_done && ana_done && (vcore_reg > CORE_RISE_MV);
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			regulator_input_supply_cnt_reg <= 32'h0;
			ana_cnt_reg  <= 32'h0;
			pgood_reg    <= 1'b0;
		end
		else
		begin
			regulator_input_supply_cnt_reg <= regulator_input_supply_cnt_next;
			ana_cnt_reg  <= ana_cnt_next;
			pgood_reg    <= pgood_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset sequencer
	// The pin is sampled; pulses shorter than one clock may be missed.
	seq_state_e  state_reg;
	seq_state_e  state_next;
	logic        hw_rst_n;
	logic [1:0]  rel_reg;
	logic [1:0]  rel_next;
	logic        boot_next;
	logic [2:0]  step_reg;
	logic [2:0]  step_next;

	assign hw_rst_n = pin_s & pgood_reg;
	always_comb
	begin
		rel_next   = hw_rst_n ? {rel_reg[0], 1'b1} : 2'h0;
		boot_next  = 1'b0;
		step_next  = step_reg;
		state_next = state_reg;
		case (state_reg)
			ST_RESET:
			begin
				step_next = 3'h0;
				if (hw_rst_n)
					state_next = ST_SEQ;
			end
			ST_SEQ:
			begin
				if (step_reg != 3'h3)
					step_next = step_reg + 3'h1;
				if (!hw_rst_n)
					state_next = ST_RESET;
				else if (rel_reg == 2'h3 && step_reg == 3'h3)
				begin
					state_next = ST_RUN;
					boot_next  = 1'b1;
				end
			end
			ST_RUN:
				if (!hw_rst_n)
					state_next = ST_RESET;
			default:
				state_next = ST_RESET;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= ST_RESET;
			rel_reg   <= 2'h0;
			step_reg  <= 3'h0;
		end
		else
		begin
			state_reg <= state_next;
			rel_reg   <= rel_next;
			step_reg  <= step_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB registers and interrupt
	logic [NUM_EVT-1:0]    status_reg;
	logic [NUM_EVT-1:0]    status_next;
	logic [NUM_EVT-1:0]    mask_reg;
	logic [NUM_EVT-1:0]    mask_next;
	logic [NUM_PERIPH-1:0] prst_reg;
	logic [NUM_PERIPH-1:0] prst_next;
	logic                  cpu_rst_next;
	logic                  rtc_lost_reg;
	logic                  rtc_lost_next;
	logic                  rtc_rst_next;
	logic [31:0]           rdata_next;
	logic                  err_next;
	logic                  acc;
	logic                  rd_status;
	logic [NUM_EVT-1:0]    evt;

	function automatic logic known_addr(input logic [11:0] a);
		known_addr = (a == ADDR_STATUS) || (a == ADDR_MASK) || (a == ADDR_PERIPH_RST)
			|| (a == ADDR_CONTROL) || (a == ADDR_LEVELS);
	endfunction

	assign acc       = psel && penable && pready;
	assign rd_status = acc && !pwrite && (paddr == ADDR_STATUS);
	assign evt[EVT_RELEASE]    = boot_next;
	assign evt[EVT_POWER_FAIL] = pgood_reg && !pgood_next;
	// Power-lost flag on RTC supply rise
	assign evt[EVT_RTC_LOST]   = rtc_s2_reg && !rtc_reset_n;
	always_comb
	begin
		// Set wins over read-to-clear
		// Clear only the bits the read returned, so an event landing between
		// setup and access is not lost
		status_next   = (status_reg & ~(rd_status ? prdata[NUM_EVT-1:0] : '0)) | evt;
		mask_next     = mask_reg;
		prst_next     = prst_reg;
		cpu_rst_next  = 1'b0;
		rtc_rst_next  = rtc_s2_reg;
		rtc_lost_next = rtc_lost_reg;
		rdata_next    = 32'h0;
		err_next      = 1'b0;
		if (acc && pwrite)
		begin
			case (paddr)
				ADDR_MASK:       mask_next = pwdata[NUM_EVT-1:0];
				ADDR_PERIPH_RST: prst_next = pwdata[NUM_PERIPH-1:0];
				ADDR_CONTROL:
				begin
					cpu_rst_next = pwdata[0];
					if (pwdata[1])
						rtc_lost_next = 1'b0;
				end
				default:         err_next = 1'b0;
			endcase
		end
		else if (psel && !penable && !pwrite)
		begin
			case (paddr)
				ADDR_STATUS:     rdata_next = {29'h0, status_reg};
				ADDR_MASK:       rdata_next = {29'h0, mask_reg};
				ADDR_PERIPH_RST: rdata_next = {16'h0, prst_reg};
				ADDR_CONTROL:    rdata_next = {30'h0, rtc_lost_reg, 1'b0};
				ADDR_LEVELS:     rdata_next = {27'h0, state_reg, pgood_reg, pin_s};
				default:         rdata_next = 32'h0;
			endcase
		end
		// Unmapped address, or a write to a read-only register
		if (psel && !penable)
			err_next = !known_addr(paddr) || (pwrite && ((paddr == ADDR_STATUS) || (paddr == ADDR_LEVELS)));
		// Power-lost set wins over a software clear in the same cycle
		if (!rtc_reset_n && rtc_s2_reg)
			rtc_lost_next = 1'b1;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_reg <= '0;
			mask_reg   <= MASK_RESET;
			prst_reg   <= PERIPH_RESET;
			cpu_soft_reset <= 1'b0;
			prdata     <= 32'h0;
			pslverr    <= 1'b0;
			pready     <= 1'b0;
			irq        <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
			prst_reg   <= prst_next;
			cpu_soft_reset <= cpu_rst_next;
			prdata     <= rdata_next;
			pslverr    <= (psel && !penable) ? err_next : 1'b0;
			pready     <= psel && !penable;
			irq        <= |(status_next & mask_next);
		end
	end
	// RTC state survives global reset; presetn clears it, and a CONTROL bit 1 write clears the power-lost flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rtc_lost_reg <= 1'b0;
			rtc_reset_n  <= 1'b0;
		end
		else
		begin
			rtc_lost_reg <= rtc_lost_next;
			rtc_reset_n  <= rtc_rst_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output stage
	logic in_rst;
	assign in_rst = (state_next != ST_RUN);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			power_ok_flag      <= 1'b0;
			global_reset_n     <= 1'b0;
			clock_gen_enable   <= 1'b0;
			clock_gen_bypass   <= 1'b0;
			bypass_use_ext_ref <= 1'b0;
			boot_start         <= 1'b0;
			periph_reset_n     <= '0;
			pin_override       <= 1'b1;
			group_high_out     <= 1'b1;
			group_low_out      <= 1'b0;
			group_z_oe         <= 1'b0;
			sync01_out         <= 1'b0;
			sync10_out         <= 1'b1;
			mem_bank_addr_pins <= BA_RESET_LEVEL;
			mem_addr_pins      <= ADDR_RESET_LEVEL;
		end
		else
		begin
			power_ok_flag      <= pgood_next;
			// RTC outputs not in this reset
			global_reset_n     <= !in_rst;
			clock_gen_enable   <= (state_next != ST_RESET);
			// Deep idle bypass by select pin
			clock_gen_bypass   <= deep_idle_mode;
			bypass_use_ext_ref <= ref_clock_select;
			boot_start         <= boot_next;
			periph_reset_n     <= in_rst ? '0 : ~prst_next;
			pin_override       <= in_rst;
			group_high_out     <= 1'b1;
			group_low_out      <= 1'b0;
			group_z_oe         <= 1'b0;
			sync01_out         <= in_rst ? (step_next >= 3'h2) : 1'b1;
			sync10_out         <= in_rst ? (step_next < 3'h2) : 1'b0;
			mem_bank_addr_pins <= BA_RESET_LEVEL;
			mem_addr_pins      <= ADDR_RESET_LEVEL;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	chk_reset_pin_holds: assert property (@(posedge pclk) disable iff (!presetn)
		!pin_s |=> !global_reset_n) else $error("reset pin low but chip not in reset");
	chk_ldo_off_good: assert property (@(posedge pclk) disable iff (!presetn)
		ldo_off_s |=> power_ok_flag) else $error("regulator off but power-good low");
	chk_good_waits: assert property (@(posedge pclk) disable iff (!presetn)
		!ldo_off_s && !pgood_reg && !regulator_input_supply_done |=> !pgood_reg) else $error("power-good too early");
	chk_hysteresis_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!ldo_off_s && pgood_reg && regulator_input_supply_s && ana_s && vcore_reg > CORE_FALL_MV |=> pgood_reg)
		else $error("power-good dropped above lower threshold");
	chk_boot_on_release: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(global_reset_n) |-> boot_start) else $error("no boot pulse on release");
	chk_release_delayed: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(hw_rst_n) |=> !global_reset_n [*2]) else $error("release not synchronised");
	chk_clock_enabled: assert property (@(posedge pclk) disable iff (!presetn)
		global_reset_n |-> clock_gen_enable) else $error("running without clock generator");
	chk_rtc_lost_set: assert property (@(posedge pclk) disable iff (!presetn)
		!rtc_reset_n && rtc_s2_reg |=> rtc_lost_reg) else $error("power-lost flag not set");
	chk_pins_forced: assert property (@(posedge pclk) disable iff (!presetn)
		!global_reset_n |-> pin_override && !group_z_oe) else $error("pins not forced in reset");
	chk_sync_levels: assert property (@(posedge pclk) disable iff (!presetn)
		global_reset_n |-> sync01_out && !sync10_out) else $error("sync groups not at reset level");
	cov_boot: cover property (@(posedge pclk) disable iff (!presetn) boot_start);
	cov_ldo_off: cover property (@(posedge pclk) disable iff (!presetn) ldo_off_s && global_reset_n);
	cov_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule
`default_nettype wire

// File: board_reset_source.sv
// Board reset source: drives the active-low reset pin with one pulse per request.
// Assumes the bench raises fire for one pclk cycle to start a pulse.
`timescale 1ns/10ps
`default_nettype none
module board_reset_source
#(
	parameter int LOW_CYCLES = 4
)
(
	input  wire logic pclk,        // System clock
	input  wire logic fire,        // Start one reset pulse
	output var logic  reset_pin_n  // Reset pin, active low
);
	int   count   = 0;
	logic pin_reg = 1'b1;
	assign reset_pin_n = pin_reg;
	always @(posedge pclk)
	begin
		if (fire)
		begin
			pin_reg <= 1'b0;
			count <= LOW_CYCLES;
		end
		else if (count > 1)
			count <= count - 1;
		else
		begin
			count <= 0;
			pin_reg <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// File: chip_reset_generator_tb.sv
// Bench for the chip reset generator: APB tasks, board pulse model, port checks.
// Assumes zero-wait APB and the register map of the package.
`timescale 1ns/10ps
`default_nettype none
module chip_reset_generator_tb;
	import reset_gen_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
	logic [11:0] paddr = 12'h000, mv = 12'h3e8;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, hit, seen_step = 1'b0;
	logic reset_pin_n, reg_off_n = 1'b0, rtc_sup = 1'b0, idle = 1'b0, sel = 1'b0;
	logic power_ok_flag, global_reset_n, rtc_reset_n, cge, byp, ext, boot_start, cpu_rst;
	logic pin_override, g_hi, g_lo, g_z, s01, s10, irq;
	logic [1:0] ba;
	logic [20:0] ad;
	logic [15:0] prst_n;
	int n_errors = 0;
	int check_count = 0;
	always #2 pclk = ~pclk;
	board_reset_source SRC (.pclk(pclk), .fire(fire), .reset_pin_n(reset_pin_n));
	chip_reset_generator DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reset_pin_n(reset_pin_n), .core_regulator_enable_n(reg_off_n), .regulator_input_supply(1'b1),
		.analog_supply(1'b1), .core_regulator_output(mv), .rtc_core_supply(rtc_sup), .deep_idle_mode(idle),
		.ref_clock_select(sel), .power_ok_flag(power_ok_flag), .global_reset_n(global_reset_n),
		.rtc_reset_n(rtc_reset_n), .clock_gen_enable(cge), .clock_gen_bypass(byp), .bypass_use_ext_ref(ext),
		.boot_start(boot_start), .periph_reset_n(prst_n), .cpu_soft_reset(cpu_rst), .pin_override(pin_override),
		.group_high_out(g_hi), .group_low_out(g_lo), .group_z_oe(g_z), .sync01_out(s01), .sync10_out(s10),
		.mem_bank_addr_pins(ba), .mem_addr_pins(ad), .irq(irq));
	//////////////////////////////////////////////////////////////////////////////
	// Sync groups must reach their reset level while reset is still held
	always @(posedge pclk)
		if (presetn && global_reset_n === 1'b0 && s01 === 1'b1 && s10 === 1'b0)
			seen_step <= 1'b1;
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			n_errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_release();
		int n;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (global_reset_n !== 1'b1 && n < 100);
		chk("boot_start", {31'h0, boot_start}, 32'h1);
		chk("clock_gen_enable", {31'h0, cge}, 32'h1);
	endtask
	task automatic pulse();
		int n;
		n = 0;
		@(posedge pclk);
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (global_reset_n !== 1'b0 && n < 10);
		chk("global_reset_n", {31'h0, global_reset_n}, 32'h0);
		chk("rtc_reset_n", {31'h0, rtc_reset_n}, 32'h1);
		wait_release();
	endtask
	task automatic complete_run();
		if (n_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#100us;
		n_errors++;
		complete_run();
	end
	initial
	begin
		logic [11:0] bad [4];
		bad = '{ADDR_STATUS, ADDR_LEVELS, 12'h020, 12'h7fc};
		repeat (2) @(posedge pclk);
		chk("pin groups", {28'h0, pin_override, g_hi, g_lo, g_z}, 32'hc);
		chk("sync groups", {s01, s10, ba, ad}, {2'b01, BA_RESET_LEVEL, ADDR_RESET_LEVEL});
		presetn <= 1'b1;
		// Regulator on: the 8 ms supply wait keeps power-good low here
		repeat (500) @(posedge pclk);
		chk("power_ok_flag", {31'h0, power_ok_flag}, 32'h0);
		chk("global_reset_n", {31'h0, global_reset_n}, 32'h0);
		// Regulator off releases reset with the pin high; a real pin pulse is sent along with it
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
		reg_off_n <= 1'b1;
		wait_release();
		chk("power_ok_flag", {31'h0, power_ok_flag}, 32'h1);
		repeat (2) @(posedge pclk);
		chk("pin_override", {31'h0, pin_override}, 32'h0);
		chk("sync step", {31'h0, seen_step}, 32'h1);
		chk("rtc_reset_n", {31'h0, rtc_reset_n}, 32'h0);
		rtc_sup <= 1'b1;
		repeat (10) @(posedge pclk);
		chk("rtc_reset_n", {31'h0, rtc_reset_n}, 32'h1);
		apb(1'b0, ADDR_CONTROL, 32'h0);
		chk("rtc lost", {31'h0, rd[1]}, 32'h1);
		apb(1'b1, ADDR_CONTROL, 32'h2);
		apb(1'b0, ADDR_CONTROL, 32'h0);
		chk("rtc lost clr", {31'h0, rd[1]}, 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status", rd & 32'h5, 32'h5);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status clr", rd & 32'h5, 32'h0);
		apb(1'b1, ADDR_MASK, 32'h7);
		apb(1'b0, ADDR_MASK, 32'h0);
		chk("mask", rd, 32'h7);
		chk("pslverr", {31'h0, err}, 32'h0);
		apb(1'b1, ADDR_MASK, 32'h1);
		pulse();
		repeat (2) @(posedge pclk);
		chk("irq", {31'h0, irq}, 32'h1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status", rd & 32'h1, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq clr", {31'h0, irq}, 32'h0);
		apb(1'b1, ADDR_MASK, 32'h0);
		pulse();
		repeat (2) @(posedge pclk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b0, ADDR_LEVELS, 32'h0);
		chk("levels", rd & 32'h1f, {27'h0, ST_RUN, 2'b11});
		apb(1'b1, ADDR_PERIPH_RST, 32'ha5);
		@(posedge pclk);
		chk("periph_reset_n", {16'h0, prst_n}, 32'hff5a);
		apb(1'b0, ADDR_PERIPH_RST, 32'h0);
		chk("periph rd", rd, 32'ha5);
		apb(1'b1, ADDR_CONTROL, 32'h1);
		hit = 1'b0;
		repeat (6)
		begin
			@(posedge pclk);
			if (cpu_rst === 1'b1)
				hit = 1'b1;
		end
		chk("cpu_soft_reset", {31'h0, hit}, 32'h1);
		chk("global_reset_n", {31'h0, global_reset_n}, 32'h1);
		foreach (bad[i])
		begin
			apb(1'b1, bad[i], 32'hff);
			chk("pslverr", {31'h0, err}, 32'h1);
		end
		apb(1'b0, 12'h020, 32'h0);
		chk("pslverr", {31'h0, err}, 32'h1);
		idle <= 1'b1;
		sel <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("bypass ext", {30'h0, byp, ext}, 32'h3);
		sel <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("bypass rtc", {30'h0, byp, ext}, 32'h2);
		complete_run();
	end
endmodule
`default_nettype wire
